// >>> testbench/host_model.sv
// Host processor model driving the serial control link
`default_nettype none
module host_model
(
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: deselected, link clock parked low
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_byte_out = 8'h00;
    end
    // Send tx bytes, then clock n_rd bytes in; a short tx ends the frame early
    task automatic frame(input logic [7:0] tx [$], input int n_rd);
        logic [7:0] sh;
        sh = 8'h00;
        cs_n_out = 1'b0;                                  // First byte is the command
        #100;
        for (int b = 0; b < tx.size() + n_rd; b++)
        begin
            sh = (b < tx.size()) ? tx[b] : ~sh;           // Toggling filler while reading
            for (int i = 7; i >= 0; i--)
            begin
                sdi_out = sh[i];                          // MSB first
                #62.5 sclk_out = 1'b1;
                rx_valid_out = 1'b0;                      // Previous answer already taken
                rx_byte_out[i] = sdo_oe_in ? sdo_in : 1'bx;   // Undriven line reads as x, matching only an x note
                #62.5 sclk_out = 1'b0;
            end
            // Hand each answer byte to the bench; byte settled a half period ago
            if (b >= tx.size())
            begin
                rx_valid_out = 1'b1;
            end
        end
        #50 cs_n_out = 1'b1;
        rx_valid_out = 1'b0;
        sdi_out = ~sdi_out;                               // Released line shows no stale bit
        #100;
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_codec_mpi_command_decoder.sv
// Self-checking bench for the host command decoder
`default_nettype none
module test_codec_mpi_command_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID = 8'h5a;                    // Identification byte; value is arbitrary
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cs_n, sclk, sdi, sdo, sdo_oe, suspend, rx_valid;
    logic [3:0] chan_en;
    logic [7:0] rx_byte;
    logic [7:0] exp_q [$];                                // Expected answer bytes, oldest first
    logic [13:0] mdl [40][4];                             // Expected RAM words per channel
    logic [3:0] cur_mask = 4'h0;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    mpi_decoder #(.ID_CODE(ID)) u_mpi_decoder (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .suspend_out(suspend),
        .chan_enable_out(chan_en));
    host_model u_host_model (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo),
        .sdo_oe_in(sdo_oe), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));
    always #5 clk_in = ~clk_in;
    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic results();
        check(exp_q.size() == 0, "answers left over");
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Each captured byte is matched against the oldest note
    always @(posedge rx_valid)
        check(exp_q.size() > 0 && rx_byte === exp_q.pop_front(), "read byte");
    // Hang guard
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            check(1'b0, "timeout");
            results();
        end
    end
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e [$]);
        exp_q = {exp_q, e};
        u_host_model.frame({cmd}, e.size());
    endtask
    // Channel mask is written, then read back after the identification byte
    task automatic sel(input logic [3:0] m);
        logic [7:0] v;
        v = {4'($urandom), m};
        u_host_model.frame({8'ha5, v}, 0);
        cur_mask = m;
        check(chan_en === m, "channel enable");
        rd(8'h25, {ID, v});
    endtask
    task automatic ram_wr(input logic [2:0] blk, input int nb, input logic live);
        logic [7:0] tx [$];
        int w;
        tx = {};
        tx.push_back({5'b11100, blk});
        for (int k = 0; k < nb; k++)
            tx.push_back(8'($urandom));
        for (int k = 1; k + 1 <= nb && live; k += 2)
        begin
            w = 8 * blk + 7 - k / 2;                      // Top word first
            for (int c = 0; c < 4; c++)
                if (cur_mask[c] || w < 20 || w > 23)
                    mdl[w][c] = {tx[k], tx[k + 1][7:2]};
        end
        u_host_model.frame(tx, 0);
    endtask
    task automatic ram_rd(input logic [2:0] blk, input logic live);
        logic [7:0] e [$];
        int c;
        c = 0;
        while (!cur_mask[c])
            c++;
        e = {ID};
        for (int k = 7; k >= 0; k--)
        begin
            e.push_back(mdl[8 * blk + k][c][13:6]);
            e.push_back({mdl[8 * blk + k][c][5:0], 2'b00});
        end
        if (!live)
            foreach (e[i]) e[i] = 8'hxx;                  // Refused: line stays undriven
        rd({5'b01100, blk}, e);
    endtask
    initial
    begin
        void'($urandom(10212));
        repeat (3) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;                                               // Stimulus stays off the clock edge
        check(chan_en === 4'h0 && suspend === 1'b0 && sdo_oe === 1'b0, "reset state");
        for (int m = 1; m < 16; m *= 2)
            sel(4'(m));
        u_host_model.frame({8'ha7, 8'($urandom), 8'($urandom), 8'h09, 8'($urandom)}, 0);
        check(chan_en === 4'h9, "descending write");
        u_host_model.frame({8'ha7, 8'h00, 8'h00}, 0);
        check(chan_en === 4'h9, "abort");
        u_host_model.frame({8'hc5, 8'h03}, 0);
        check(chan_en === 4'h9, "forbidden");
        rd(8'h45, {8'hxx, 8'hxx});
        sel(4'h1);
        ram_wr(3'h0, 16, 1'b1);
        ram_wr(3'h0, 5, 1'b1);
        ram_rd(3'h0, 1'b1);
        ram_wr(3'h2, 16, 1'b1);
        sel(4'h2);
        ram_wr(3'h2, 16, 1'b1);
        sel(4'h1);
        ram_rd(3'h2, 1'b1);
        u_host_model.frame({8'hb5, 8'h01}, 0);
        check(suspend === 1'b1, "suspend entry");
        ram_wr(3'h0, 16, 1'b0);
        ram_rd(3'h0, 1'b0);
        sel(4'h3);
        u_host_model.frame({8'h88, 8'h00}, 0);
        check(suspend === 1'b0, "suspend exit");
        sel(4'h1);
        u_host_model.frame({8'h88, 8'h01}, 0);
        check(suspend === 1'b0, "broadcast");
        sel(4'h2);
        u_host_model.frame({8'h88, 8'h01}, 0);
        check(suspend === 1'b1, "all down");
        u_host_model.frame({8'hb5, 8'h00}, 0);
        sel(4'h1);
        ram_rd(3'h0, 1'b1);
        results();
    end
endmodule
`default_nettype wire

// >>> verilog/coef_if.sv
// Carrier between the decoder and the coefficient RAM
`default_nettype none
interface coef_if;
    logic wr_en;                                          // One-cycle write strobe
    logic [5:0] wr_addr;                                  // Word address 0..39
    logic [3:0] wr_chan_mask;                             // Channels for per-channel words
    logic [13:0] wr_data;                                 // Word to store
    logic [5:0] rd_addr;                                  // Word address to read
    logic [1:0] rd_chan;                                  // Channel for per-channel words
    logic [13:0] rd_data;                                 // Word read back
    modport decoder (output wr_en, wr_addr, wr_chan_mask, wr_data, rd_addr, rd_chan, input rd_data);
    modport ram (input wr_en, wr_addr, wr_chan_mask, wr_data, rd_addr, rd_chan, output rd_data);
endinterface
`default_nettype wire

// >>> verilog/coef_ram.sv
// Coefficient RAM: shared words plus per-channel tone words
`default_nettype none
module coef_ram
(
    input wire logic clk_in,
    coef_if.ram cif
);
    // Shared store, one word per address; tone slots there are unused
    logic [13:0] shared_mem [0:39];
    // Per-channel tone store, four words per channel
    logic [13:0] tone_mem [0:3][0:3];

    // Tone words live per channel
    logic wr_tone;
    logic rd_tone;
    logic [1:0] wr_tone_idx;
    logic [1:0] rd_tone_idx;
    logic [5:0] wr_off;
    logic [5:0] rd_off;
    assign wr_tone = (cif.wr_addr >= mpi_decoder_pkg::TONE_FIRST) && (cif.wr_addr <= mpi_decoder_pkg::TONE_LAST);
    assign rd_tone = (cif.rd_addr >= mpi_decoder_pkg::TONE_FIRST) && (cif.rd_addr <= mpi_decoder_pkg::TONE_LAST);
    assign wr_off = cif.wr_addr - mpi_decoder_pkg::TONE_FIRST;
    assign rd_off = cif.rd_addr - mpi_decoder_pkg::TONE_FIRST;
    assign wr_tone_idx = wr_off[1:0];
    assign rd_tone_idx = rd_off[1:0];

    // Read is combinational so the decoder can load the next byte at once
    assign cif.rd_data = rd_tone ? tone_mem[cif.rd_chan][rd_tone_idx] : shared_mem[cif.rd_addr];

    // Write port; tone words go to every channel in the mask
    always_ff @(posedge clk_in)
    begin
        if (cif.wr_en && !wr_tone)
        begin
            shared_mem[cif.wr_addr] <= cif.wr_data;
        end
        for (int c = 0; c < 4; c++)
        begin
            if (cif.wr_en && wr_tone && cif.wr_chan_mask[c])
            begin
                tone_mem[c][wr_tone_idx] <= cif.wr_data;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/mpi_decoder.sv
// Host control interface command decoder for a four-channel codec
// Function
// - Suspend when PLL off and all channels down
// - Suspended: registers work, RAM commands ignored
// - Channel enable bits 3..0 map channels 4..1
// - Writes reach every enabled channel
// - Reads start with identification byte
// - Bit 7 direction, 6..5 type, 4..0 address
// - Type 00 local, 01 shared, 11 RAM, 10 forbidden
// - Address is register or RAM block
// - Register commands move 1..4 bytes, descending
// - Chip select rise aborts register transfer
// - Shared commands ignore channel enables
// - RAM holds 40 words of 14 bits
// - Block n (0..4) covers words 8n..8n+7
// - Words 20..23 stored per channel
// - Word write two bytes, low bits dropped
// - Word read 16 bits, low bits filler
// - RAM command walks block top to bottom
// - Chip select rise aborts RAM transfer
// - Channels powered down after reset
`default_nettype none
module mpi_decoder
#(
    parameter logic [7:0] ID_CODE = 8'h5a   // Identification byte; value is arbitrary
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,               // Chip select from host, active low
    input wire logic sclk_in,               // Serial link clock from host
    input wire logic sdi_in,                // Serial data from host
    output logic sdo_out,                   // Serial data to host
    output logic sdo_oe_out,                // High while sdo_out is driven
    output logic suspend_out,               // Chip in suspend mode
    output logic [3:0] chan_enable_out      // Channels selected for programming
);
    // Pin synchronisers, two stages each, plus a history stage for chip select and link clock
    logic [1:0] cs_sync_r;
    logic [1:0] sclk_sync_r;
    logic [1:0] sdi_sync_r;
    logic cs_hist_r;
    logic sclk_hist_r;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cs_sync_r <= 2'h3;
            sclk_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            cs_hist_r <= 1'b1;
            sclk_hist_r <= 1'b0;
        end
        else
        begin
            cs_sync_r <= {cs_sync_r[0], cs_n_in};
            sclk_sync_r <= {sclk_sync_r[0], sclk_in};
            sdi_sync_r <= {sdi_sync_r[0], sdi_in};
            cs_hist_r <= cs_sync_r[1];
            sclk_hist_r <= sclk_sync_r[1];
        end
    end

    // Edge events on the synchronised pins
    logic cs_n_s;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    assign cs_n_s = cs_sync_r[1];
    assign cs_rise = cs_n_s && !cs_hist_r;
    assign cs_fall = !cs_n_s && cs_hist_r;
    assign sclk_rise = sclk_sync_r[1] && !sclk_hist_r && !cs_n_s;
    assign sclk_fall = !sclk_sync_r[1] && sclk_hist_r && !cs_n_s;

    // Decoder state and counters
    mpi_decoder_pkg::dec_state_t state_r;
    mpi_decoder_pkg::dec_state_t state_nxt;
    logic [2:0] bit_cnt_r;                  // Bits taken in current byte
    logic [6:0] rx_r;                       // Bits shifted in so far
    logic [7:0] cmd_r;                      // Latched command byte
    logic [4:0] left_r;                     // Data bytes still to move
    logic [4:0] left_nxt;
    logic [7:0] tx_byte_r;                  // Byte being shifted out
    logic [7:0] tx_nxt;
    logic [7:0] hold_r;                     // High byte of a coefficient word
    logic sdo_r;
    logic sdo_oe_r;

    // Software-visible state
    logic [7:0] chan_prog_enable_r;         // channel_select_register
    logic pll_off_r;                        // pll_shutdown_bit
    logic [3:0] chan_pd_r;                  // Per-channel power-down
    logic suspend_r;
    logic [7:0] loc_mem [0:3][0:31];        // Local registers, per channel
    logic [7:0] glob_mem [0:31];            // Shared registers

    // Byte assembly
    logic byte_done;
    logic [7:0] rx_full;
    assign rx_full = {rx_r, sdi_sync_r[1]};
    assign byte_done = sclk_rise && (bit_cnt_r == 3'h7) && (state_r != mpi_decoder_pkg::ST_IDLE);

    // Command fields of the byte just received
    logic new_write;
    logic [1:0] new_ct;
    logic [4:0] new_addr;
    assign new_write = rx_full[mpi_decoder_pkg::DIR_BIT];
    assign new_ct = rx_full[mpi_decoder_pkg::CT_HI:mpi_decoder_pkg::CT_LO];
    assign new_addr = rx_full[4:0];
    logic new_is_reg;
    logic new_is_ram;
    logic new_ok;
    assign new_is_reg = (new_ct == mpi_decoder_pkg::CT_LOCAL) || (new_ct == mpi_decoder_pkg::CT_SHARED);
    // Blocks past the fifth and any RAM access while suspended are ignored
    assign new_is_ram = (new_ct == mpi_decoder_pkg::CT_RAM) && (new_addr < 5'(mpi_decoder_pkg::NUM_BLOCKS));
    assign new_ok = new_is_reg || (new_is_ram && !suspend_r);

    // Latched command fields
    logic cur_ram;
    logic cur_local;
    logic [1:0] cur_ct;
    assign cur_ct = cmd_r[mpi_decoder_pkg::CT_HI:mpi_decoder_pkg::CT_LO];
    assign cur_ram = (cur_ct == mpi_decoder_pkg::CT_RAM);
    assign cur_local = (cur_ct == mpi_decoder_pkg::CT_LOCAL);

    // Address of the register or word for the byte at hand
    logic [4:0] left_m1;
    logic [4:0] reg_addr;
    logic [5:0] word_addr;
    logic word_lo;
    assign left_m1 = left_r - 5'h01;
    assign reg_addr = {cmd_r[4:2], left_m1[1:0]};
    assign word_addr = {cmd_r[2:0], left_m1[3:1]};
    assign word_lo = !left_r[0] ? 1'b0 : 1'b1;                             // Odd count: low byte

    // Read channel: lowest enabled one, as the host enables only one
    logic [1:0] rd_chan;
    assign rd_chan = chan_prog_enable_r[0] ? 2'h0 : chan_prog_enable_r[1] ? 2'h1 :
                     chan_prog_enable_r[2] ? 2'h2 : 2'h3;

    // Register read value, with live bits overlaid on the stored byte
    logic [7:0] loc_rd;
    logic [7:0] glob_rd;
    logic [7:0] reg_rd;
    logic [7:0] chip_pwr_rd;
    assign chip_pwr_rd = glob_mem[mpi_decoder_pkg::ADDR_CHIP_PWR] & ~(8'h01 << mpi_decoder_pkg::PLL_BIT_POS)
                         | ({7'h00, pll_off_r} << mpi_decoder_pkg::PLL_BIT_POS);
    assign loc_rd = (reg_addr == mpi_decoder_pkg::ADDR_CHAN_PWR) ?
                    (loc_mem[rd_chan][reg_addr] & ~(8'h01 << mpi_decoder_pkg::CHAN_PD_BIT_POS)
                     | ({7'h00, chan_pd_r[rd_chan]} << mpi_decoder_pkg::CHAN_PD_BIT_POS)) : loc_mem[rd_chan][reg_addr];
    assign glob_rd = (reg_addr == mpi_decoder_pkg::ADDR_CHAN_SEL) ? chan_prog_enable_r :
                     (reg_addr == mpi_decoder_pkg::ADDR_CHIP_PWR) ? chip_pwr_rd : glob_mem[reg_addr];
    assign reg_rd = cur_local ? loc_rd : glob_rd;

    // Coefficient RAM port
    coef_if cif ();
    coef_ram u_coef_ram
    (
        .clk_in (clk_in),
        .cif (cif.ram)
    );
    logic [15:0] word_rd;
    assign word_rd = {cif.rd_data, {mpi_decoder_pkg::FILL_BITS{1'b0}}};
    assign cif.rd_addr = word_addr;
    assign cif.rd_chan = rd_chan;
    assign cif.wr_addr = word_addr;
    assign cif.wr_chan_mask = chan_prog_enable_r[3:0];
    assign cif.wr_data = {hold_r, rx_full[7:2]};
    assign cif.wr_en = byte_done && (state_r == mpi_decoder_pkg::ST_WDATA) && cur_ram && word_lo;

    // Write strobes for registers
    logic reg_wr;
    assign reg_wr = byte_done && (state_r == mpi_decoder_pkg::ST_WDATA) && !cur_ram;

    // Next state and counts
    always_comb
    begin
        state_nxt = state_r;
        left_nxt = left_r;
        tx_nxt = tx_byte_r;
        case (state_r)
            mpi_decoder_pkg::ST_IDLE:
            begin
                if (!cs_n_s)
                begin
                    state_nxt = mpi_decoder_pkg::ST_CMD;
                end
            end
            mpi_decoder_pkg::ST_CMD:
            begin
                if (byte_done && !new_ok)
                begin
                    state_nxt = mpi_decoder_pkg::ST_IGNORE;
                end
                else if (byte_done)
                begin
                    left_nxt = new_is_reg ? {3'h0, new_addr[1:0]} + 5'h01 : mpi_decoder_pkg::RAM_BYTES;
                    state_nxt = new_write ? mpi_decoder_pkg::ST_WDATA : mpi_decoder_pkg::ST_RDATA;
                    tx_nxt = ID_CODE;
                end
            end
            mpi_decoder_pkg::ST_WDATA, mpi_decoder_pkg::ST_RDATA:
            begin
                if (byte_done)
                begin
                    left_nxt = left_r - 5'h01;
                    if (left_r == 5'h00)
                    begin
                        state_nxt = mpi_decoder_pkg::ST_IGNORE;
                    end
                    else if (state_r == mpi_decoder_pkg::ST_RDATA)
                    begin
                        // Walk downward, high byte of each word first
                        tx_nxt = !cur_ram ? reg_rd : word_lo ? word_rd[7:0] : word_rd[15:8];
                    end
                    if (state_r == mpi_decoder_pkg::ST_WDATA && left_r == 5'h01)
                    begin
                        state_nxt = mpi_decoder_pkg::ST_IGNORE;
                    end
                end
            end
            mpi_decoder_pkg::ST_IGNORE:
            begin
                state_nxt = mpi_decoder_pkg::ST_IGNORE;
            end
            default:
            begin
                state_nxt = mpi_decoder_pkg::ST_IDLE;
            end
        endcase
        // Deselect ends any transfer; finished accesses stand
        if (cs_n_s)
        begin
            state_nxt = mpi_decoder_pkg::ST_IDLE;
        end
    end

    // Transfer state registers
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= mpi_decoder_pkg::ST_IDLE;
            left_r <= 5'h00;
            tx_byte_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            left_r <= left_nxt;
            tx_byte_r <= tx_nxt;
        end
    end

    // Shift-in and command latch
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bit_cnt_r <= 3'h0;
            rx_r <= 7'h00;
            cmd_r <= 8'h00;
            hold_r <= 8'h00;
        end
        else if (state_r == mpi_decoder_pkg::ST_IDLE)
        begin
            bit_cnt_r <= 3'h0;
        end
        else if (sclk_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_r <= rx_full[6:0];
            if (byte_done && state_r == mpi_decoder_pkg::ST_CMD)
            begin
                cmd_r <= rx_full;
            end
            if (byte_done && state_r == mpi_decoder_pkg::ST_WDATA && !word_lo)
            begin
                hold_r <= rx_full;
            end
        end
    end

    // Serial output changes on the falling link edge, MSB first
    logic [2:0] tx_idx;
    assign tx_idx = 3'h7 - bit_cnt_r;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else
        begin
            sdo_oe_r <= (state_r == mpi_decoder_pkg::ST_RDATA) && !cs_n_s;
            if (sclk_fall && state_r == mpi_decoder_pkg::ST_RDATA)
            begin
                sdo_r <= tx_byte_r[tx_idx];
            end
        end
    end

    // Control registers and suspend
    logic chan_pd_wr;
    assign chan_pd_wr = reg_wr && cur_local && (reg_addr == mpi_decoder_pkg::ADDR_CHAN_PWR);
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            chan_prog_enable_r <= mpi_decoder_pkg::CHAN_SEL_RESET;
            pll_off_r <= mpi_decoder_pkg::PLL_RESET;
            chan_pd_r <= mpi_decoder_pkg::CHAN_PD_RESET;
            suspend_r <= 1'b0;
        end
        else
        begin
            suspend_r <= pll_off_r && (&chan_pd_r);
            if (reg_wr && !cur_local && reg_addr == mpi_decoder_pkg::ADDR_CHAN_SEL)
            begin
                chan_prog_enable_r <= rx_full;
            end
            if (reg_wr && !cur_local && reg_addr == mpi_decoder_pkg::ADDR_CHIP_PWR)
            begin
                pll_off_r <= rx_full[mpi_decoder_pkg::PLL_BIT_POS];
            end
            for (int c = 0; c < mpi_decoder_pkg::NUM_CHAN; c++)
            begin
                if (chan_pd_wr && chan_prog_enable_r[c])
                begin
                    chan_pd_r[c] <= rx_full[mpi_decoder_pkg::CHAN_PD_BIT_POS];
                end
            end
        end
    end

    // Register storage; local writes go to every enabled channel
    always_ff @(posedge clk_in)
    begin
        if (reg_wr && !cur_local)
        begin
            glob_mem[reg_addr] <= rx_full;
        end
        for (int c = 0; c < mpi_decoder_pkg::NUM_CHAN; c++)
        begin
            if (reg_wr && cur_local && chan_prog_enable_r[c])
            begin
                loc_mem[c][reg_addr] <= rx_full;
            end
        end
    end

    assign sdo_out = sdo_r;
    assign sdo_oe_out = sdo_oe_r;
    assign suspend_out = suspend_r;
    assign chan_enable_out = chan_prog_enable_r[3:0];

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    suspend_entry_a: assert property ((pll_off_r && &chan_pd_r) |=> suspend_out)
        else $error("suspend not entered");
    suspend_ram_a: assert property (suspend_r |-> !cif.wr_en)
        else $error("RAM written while suspended");
    id_first_a: assert property ((byte_done && state_r == mpi_decoder_pkg::ST_CMD && new_ok && !new_write)
        |=> tx_byte_r == ID_CODE && state_r == mpi_decoder_pkg::ST_RDATA)
        else $error("read did not start with id");
    reg_count_a: assert property ((byte_done && state_r == mpi_decoder_pkg::ST_CMD && new_is_reg)
        |=> left_r == {3'h0, $past(rx_full[1:0])} + 5'h01)
        else $error("wrong register byte count");
    cs_abort_a: assert property ((cs_n_s && state_r != mpi_decoder_pkg::ST_IDLE)
        |=> state_r == mpi_decoder_pkg::ST_IDLE ##1 !sdo_oe_out)
        else $error("deselect did not abort");
    forbid_ign_a: assert property ((byte_done && state_r == mpi_decoder_pkg::ST_CMD
        && new_ct == mpi_decoder_pkg::CT_FORBID) |=> state_r == mpi_decoder_pkg::ST_IGNORE)
        else $error("forbidden type not ignored");
    ram_walk_a: assert property (cif.wr_en |-> cif.wr_addr == {cmd_r[2:0], left_r[3:1]} && left_r[0]
        && cif.wr_addr < 6'h28)
        else $error("RAM word order wrong");
    bcast_pd_a: assert property (chan_pd_wr |=>
        ((chan_pd_r ^ {4{$past(rx_full[mpi_decoder_pkg::CHAN_PD_BIT_POS])}}) & $past(chan_prog_enable_r[3:0])) == 4'h0
        && ((chan_pd_r ^ $past(chan_pd_r)) & ~$past(chan_prog_enable_r[3:0])) == 4'h0)
        else $error("write missed an enabled channel");
    ram_cmd_c: cover property (byte_done && state_r == mpi_decoder_pkg::ST_CMD && new_is_ram && new_write);
    reg_read_c: cover property (byte_done && state_r == mpi_decoder_pkg::ST_RDATA && left_r == 5'h00);
    abort_c: cover property (cs_rise && state_r == mpi_decoder_pkg::ST_WDATA);
    select_c: cover property (cs_fall && state_r == mpi_decoder_pkg::ST_IDLE);
endmodule
`default_nettype wire

// >>> verilog/mpi_decoder_pkg.sv
// Constants, field layouts and state codes for the command decoder
`default_nettype none
package mpi_decoder_pkg;
    // Command byte layout
    localparam int DIR_BIT = 7;             // 1 = write, 0 = read
    localparam int CT_HI = 6;               // Command type field, upper bit
    localparam int CT_LO = 5;               // Command type field, lower bit
    localparam int ADDR_W = 5;              // Address field width
    localparam logic [1:0] CT_LOCAL = 2'b00;
    localparam logic [1:0] CT_SHARED = 2'b01;
    localparam logic [1:0] CT_FORBID = 2'b10;
    localparam logic [1:0] CT_RAM = 2'b11;
    // Register addresses of interest
    localparam logic [4:0] ADDR_CHAN_SEL = 5'h05;   // channel_select_register
    localparam logic [4:0] ADDR_CHIP_PWR = 5'h15;   // chip_power_control_register
    localparam logic [4:0] ADDR_CHAN_PWR = 5'h08;   // Per-channel power-down register
    localparam int PLL_BIT_POS = 0;                  // pll_shutdown_bit position
    localparam int CHAN_PD_BIT_POS = 0;              // Channel power-down bit position
    // Reset values
    localparam logic [7:0] CHAN_SEL_RESET = 8'h00;
    localparam logic PLL_RESET = 1'b0;
    localparam logic [3:0] CHAN_PD_RESET = 4'hf;     // All channels down after reset
    // Channels and coefficient RAM geometry
    localparam int NUM_CHAN = 4;
    localparam int RAM_WORDS = 40;
    localparam int BLOCK_WORDS = 8;
    localparam int NUM_BLOCKS = 5;
    localparam int WORD_BITS = 14;
    localparam int RAM_AW = 6;
    localparam logic [5:0] TONE_FIRST = 6'h14;       // Word 20
    localparam logic [5:0] TONE_LAST = 6'h17;        // Word 23
    localparam logic [4:0] RAM_BYTES = 5'h10;        // 8 words of 2 bytes
    localparam int FILL_BITS = 2;                    // Discarded low bits of a word
    // Decoder states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b011,
        ST_IGNORE = 3'b100
    } dec_state_t;
endpackage
`default_nettype wire
